// ==== dbgx_debug_exception_logic.sv ====
// Purpose: Detects debug conditions, raises the debug exception and keeps the
//          resume and trap flags and the debug status flags.
// Assumes: Pipeline reports fetches, data accesses, retirements and task
//          switches on ref_clk; slot match vectors are already compared.
// Notes:   All inputs come from logic on the same clock, so none is synchronised.
// Operation
// - Fetch match on exec slot raises fault
// - Instruction breakpoint outranks all other exceptions
// - Each condition sets its own status flag
// - Write, IO, data slots raise traps
// - Data traps wait for instruction completion
// - Fault and trap may report together
// - Resume flag masks instruction breakpoints only
// - Fault entry sets resume flag, breakpoint excepted
// - Only dword return or task return restore
// - Completion clears resume flag, listed exceptions aside
// - Exact match enables are ignored
// - Repeated strings trap after matching iteration
// - Guarded debug register move raises fault
// - Trap flag set during instruction steps
// - Step entry clears trap flag
// - Loaded trap flag steps after first instruction
// - Soft and overflow interrupts clear trap flag
// - Step first, then pending external interrupt
// - Task debug trap bit raises exception
// - Debug conditions use vector one
`timescale 1ns/1ns
`default_nettype none

module dbgx_debug_exception_logic
(
	input  wire logic                            ref_clk,
	input  wire logic                            reset,
	input  wire logic                            clk_en,
	input  wire dbgx_pkg::dbgx_ctrl_t            debug_control_register,
	input  wire logic                            fetch_valid,
	input  wire logic [dbgx_pkg::DBGX_SLOTS-1:0] fetch_slot_match,
	input  wire logic                            debug_reg_move,
	input  wire logic                            data_valid,
	input  wire logic                            data_write,
	input  wire logic                            data_is_io,
	input  wire logic [dbgx_pkg::DBGX_SLOTS-1:0] data_slot_match,
	input  wire logic                            rep_iter_done,
	input  wire dbgx_pkg::dbgx_retire_t          retire,
	input  wire dbgx_pkg::dbgx_task_t            task_switch,
	input  wire logic                            other_fault,
	input  wire logic                            ext_int_pending,
	input  wire logic                            status_clear,
	input  wire dbgx_pkg::dbgx_status_t          status_clear_mask,
	output logic                                 debug_exception,
	output logic                                 exc_is_fault,
	output logic                                 exc_is_trap,
	output logic [7:0]                           exc_vector,
	output logic                                 hold_instruction,
	output logic                                 block_other_exc,
	output logic                                 ext_int_grant,
	output logic                                 resume_flag,
	output logic                                 trap_flag,
	output dbgx_pkg::dbgx_status_t               debug_status_register
);
	import dbgx_pkg::*;

	// Small state machine: after a step trap it opens a one-cycle window in
	// which a still pending external interrupt is granted ahead of the handler.
	typedef enum logic [1:0] {
		DBGX_ST_RUN   = 2'b00,
		DBGX_ST_STEP  = 2'b01,
		DBGX_ST_GRANT = 2'b11
	} dbgx_state_t;

	dbgx_state_t              state_q;
	dbgx_state_t              state_d;
	logic                     exc_q;
	logic                     fault_q;
	logic                     trap_q;
	logic [7:0]               vector_q;
	logic                     hold_q;
	logic                     block_q;
	logic                     grant_q;
	logic                     rf_q;
	logic                     rf_d;
	logic                     tf_q;
	logic                     tf_d;
	dbgx_status_t             status_q;
	logic [DBGX_SLOTS-1:0]    pend_hit_q;

	logic [DBGX_SLOTS-1:0]    slot_en;
	logic [DBGX_SLOTS-1:0]    exec_slot;
	logic [DBGX_SLOTS-1:0]    write_slot;
	logic [DBGX_SLOTS-1:0]    io_slot;
	logic [DBGX_SLOTS-1:0]    rw_slot;
	logic [DBGX_SLOTS-1:0]    ibp_hits;
	logic [DBGX_SLOTS-1:0]    data_hits;
	logic [DBGX_SLOTS-1:0]    all_data_hits;
	logic                     ibp_fault;
	logic                     gd_fault;
	logic                     any_fault;
	logic                     data_point;
	logic                     data_trap;
	logic                     step_trap;
	logic                     task_trap;
	logic                     any_trap;
	logic                     fault_entry;

	// Picks every slot whose access type field holds the given encoding.
	function automatic logic [DBGX_SLOTS-1:0] slots_of_type
	(
		input logic [2*DBGX_SLOTS-1:0] types,
		input logic [1:0]              code
	);
		logic [DBGX_SLOTS-1:0] sel;
		sel = '0;
		for (int i = 0; i < DBGX_SLOTS; i++)
		begin
			sel[i] = (types[2*i +: 2] == code);
		end
		return sel;
	endfunction : slots_of_type

	// The exact-match enables are deliberately not consulted: data matching
	// behaves the same whichever way software leaves them.
	assign slot_en    = debug_control_register.global_slot_enable |
	                    debug_control_register.local_slot_enable;
	assign exec_slot  = slots_of_type(debug_control_register.breakpoint_access_type_field,
	                                  DBGX_AT_EXEC);
	assign write_slot = slots_of_type(debug_control_register.breakpoint_access_type_field,
	                                  DBGX_AT_WRITE);
	assign io_slot    = slots_of_type(debug_control_register.breakpoint_access_type_field,
	                                  DBGX_AT_IO);
	assign rw_slot    = slots_of_type(debug_control_register.breakpoint_access_type_field,
	                                  DBGX_AT_DATA_RW);

	// Instruction breakpoints are checked on the fetch, before execution, and
	// are masked while the resume flag is set.
	assign ibp_hits  = (fetch_valid && !rf_q) ? (fetch_slot_match & slot_en & exec_slot)
	                                          : '0;
	assign ibp_fault = |ibp_hits;

	// A guarded debug register move faults before the move runs.
	assign gd_fault  = debug_reg_move && debug_control_register.register_access_guard;
	assign any_fault = ibp_fault || gd_fault;

	// Data and I/O matches are traps, not gated by the resume flag.
	always_comb
	begin
		data_hits = '0;
		if (data_valid)
		begin
			if (data_is_io)
			begin
				data_hits = data_slot_match & slot_en & io_slot;
			end
			else
			begin
				data_hits = data_slot_match & slot_en &
				            (rw_slot | (data_write ? write_slot : '0));
			end
		end
	end

	// Matches are collected over the instruction and reported only at its end,
	// or at the end of the string iteration that touched the location.
	assign all_data_hits = pend_hit_q | data_hits;
	assign data_point    = retire.valid || rep_iter_done;
	assign data_trap     = data_point && (|all_data_hits);

	// The trap flag as it stood during the instruction decides the step; a flag
	// written by this same retirement only affects the next one.
	assign step_trap = retire.valid && tf_q;

	// The incoming task's debug trap bit raises the exception on arrival. A
	// handler task with this bit set would loop here forever.
	assign task_trap = task_switch.valid && task_switch.debug_trap_bit;

	assign any_trap  = data_trap || step_trap || task_trap;

	// Entry into any fault handler other than an instruction breakpoint.
	assign fault_entry = (gd_fault && !ibp_fault) || (other_fault && !ibp_fault);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			pend_hit_q <= '0;
		end
		else if (clk_en)
		begin
			if (data_point || any_fault || other_fault)
			begin
				pend_hit_q <= '0;
			end
			else
			begin
				pend_hit_q <= all_data_hits;
			end
		end
	end

	// Exception report: one pulse on vector 1 carrying fault and trap classes.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			exc_q    <= 1'b0;
			fault_q  <= 1'b0;
			trap_q   <= 1'b0;
			vector_q <= DBGX_VEC_DEBUG;
			hold_q   <= 1'b0;
			block_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			exc_q    <= any_fault || any_trap;
			fault_q  <= any_fault;
			trap_q   <= any_trap;
			vector_q <= DBGX_VEC_DEBUG;
			hold_q   <= any_fault;
			block_q  <= ibp_fault;
		end
	end

	// Resume flag update; a later branch overrides an earlier one, so fault entry wins.
	always_comb
	begin
		rf_d = rf_q;
		if (retire.valid)
		begin
			case (retire.kind)
				DBGX_RK_DW_PLAIN_INTERRUPT_RETURN:
				begin
					rf_d = retire.rf_image;
				end
				DBGX_RK_TS_BRANCH:
				begin
					rf_d = rf_q;
				end
				default:
				begin
					rf_d = 1'b0;
				end
			endcase
		end
		if (task_switch.valid && task_switch.is_return)
		begin
			rf_d = task_switch.rf_image;
		end
		if (fault_entry)
		begin
			rf_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rf_q <= DBGX_RF_RESET;
		end
		else if (clk_en)
		begin
			rf_q <= rf_d;
		end
	end

	// Trap flag update. Privilege changes do not touch it.
	always_comb
	begin
		tf_d = tf_q;
		if (retire.valid)
		begin
			if (retire.tf_write)
			begin
				tf_d = retire.tf_value;
			end
			if ((retire.kind == DBGX_RK_SOFT_INT) || (retire.kind == DBGX_RK_OVF_INT))
			begin
				tf_d = 1'b0;
			end
		end
		if (task_switch.valid)
		begin
			tf_d = task_switch.tf_image;
		end
		if (step_trap)
		begin
			tf_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			tf_q <= DBGX_TF_RESET;
		end
		else if (clk_en)
		begin
			tf_q <= tf_d;
		end
	end

	// The step is always taken first; the interrupt is granted two cycles
	// later, once the flag is clear, so its handler never runs stepped.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			DBGX_ST_RUN:
			begin
				if (step_trap && ext_int_pending)
				begin
					state_d = DBGX_ST_STEP;
				end
			end
			DBGX_ST_STEP:
			begin
				state_d = ext_int_pending ? DBGX_ST_GRANT : DBGX_ST_RUN;
			end
			DBGX_ST_GRANT:
			begin
				state_d = DBGX_ST_RUN;
			end
			default:
			begin
				state_d = DBGX_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= DBGX_ST_RUN;
			grant_q <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			grant_q <= (state_d == DBGX_ST_GRANT);
		end
	end

	// Sticky status flags; a new condition wins over a software clear in the
	// same cycle so that no report is lost.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			status_q <= DBGX_STATUS_RESET;
		end
		else if (clk_en)
		begin
			status_q <= (status_clear ? (status_q & ~status_clear_mask) : status_q) |
			            dbgx_status_t'({task_trap, gd_fault, step_trap,
			                            (ibp_hits | (data_trap ? all_data_hits
			                                                   : {DBGX_SLOTS{1'b0}}))});
		end
	end

	assign debug_exception       = exc_q;
	assign exc_is_fault          = fault_q;
	assign exc_is_trap           = trap_q;
	assign exc_vector            = vector_q;
	assign hold_instruction      = hold_q;
	assign block_other_exc       = block_q;
	assign ext_int_grant         = grant_q;
	assign resume_flag           = rf_q;
	assign trap_flag             = tf_q;
	assign debug_status_register = status_q;

endmodule : dbgx_debug_exception_logic

`default_nettype wire

// ==== dbgx_pkg.sv ====
// Purpose: Shared constants and carrier types for the debug exception logic.
// Assumes: Four breakpoint slots, each with a two-bit access type field.
// Notes:   Address comparison and length masking happen outside this block.
package dbgx_pkg;

	localparam int unsigned DBGX_SLOTS = 4;

	// Breakpoint access type field encodings.
	localparam logic [1:0] DBGX_AT_EXEC     = 2'h0;
	localparam logic [1:0] DBGX_AT_WRITE    = 2'h1;
	localparam logic [1:0] DBGX_AT_IO       = 2'h2;
	localparam logic [1:0] DBGX_AT_DATA_RW  = 2'h3;

	// Interrupt vectors of the debug exception and of the breakpoint instruction.
	localparam logic [7:0] DBGX_VEC_DEBUG   = 8'h01;
	localparam logic [7:0] DBGX_VEC_BPINSN  = 8'h03;

	// Reset values of the processor flags held here.
	localparam logic       DBGX_RF_RESET    = 1'b0;
	localparam logic       DBGX_TF_RESET    = 1'b0;

	// Debug control register bits that steer this block.
	typedef struct packed {
		logic                       register_access_guard;
		logic                       global_exact_match;
		logic                       local_exact_match;
		logic [DBGX_SLOTS-1:0]      global_slot_enable;
		logic [DBGX_SLOTS-1:0]      local_slot_enable;
		logic [2*DBGX_SLOTS-1:0]    breakpoint_access_type_field;
	} dbgx_ctrl_t;

	// Debug status register flags kept by this block.
	typedef struct packed {
		logic                       task_switch_status_flag;
		logic                       access_detect_flag;
		logic                       step_status_flag;
		logic [DBGX_SLOTS-1:0]      slot_hit_flag;
	} dbgx_status_t;

	localparam dbgx_status_t DBGX_STATUS_RESET = '0;

	// Kind of instruction reported at retirement.
	typedef enum logic [2:0] {
		DBGX_RK_NORMAL    = 3'h0,
		DBGX_RK_DW_PLAIN_INTERRUPT_RETURN   = 3'h1,
		DBGX_RK_PLAIN_PLAIN_INTERRUPT_RETURN = 3'h2,
		DBGX_RK_FLAG_POP  = 3'h3,
		DBGX_RK_TS_BRANCH = 3'h4,
		DBGX_RK_SOFT_INT  = 3'h5,
		DBGX_RK_OVF_INT   = 3'h6
	} dbgx_retire_kind_t;

	// One retirement report from the pipeline.
	typedef struct packed {
		logic                       valid;
		dbgx_retire_kind_t          kind;
		logic                       tf_write;
		logic                       tf_value;
		logic                       rf_image;
	} dbgx_retire_t;

	// One task switch report from the pipeline.
	typedef struct packed {
		logic                       valid;
		logic                       is_return;
		logic                       tf_image;
		logic                       rf_image;
		logic                       debug_trap_bit;
	} dbgx_task_t;

endpackage : dbgx_pkg

// ==== dbgx_debug_exception_logic_checker.sv ====
// Purpose: Port-level assertions for the debug exception logic.
// Assumes: One clock; reset is asynchronous and active high.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ns
`default_nettype none
module dbgx_debug_exception_logic_checker
(
	input wire logic                   ref_clk,
	input wire logic                   reset,
	input wire logic                   clk_en,
	input wire dbgx_pkg::dbgx_ctrl_t   debug_control_register,
	input wire logic                   fetch_valid,
	input wire logic [3:0]             fetch_slot_match,
	input wire logic                   debug_reg_move,
	input wire logic                   data_valid,
	input wire logic                   rep_iter_done,
	input wire dbgx_pkg::dbgx_retire_t retire,
	input wire dbgx_pkg::dbgx_task_t   task_switch,
	input wire logic                   other_fault,
	input wire logic                   ext_int_pending,
	input wire logic                   status_clear,
	input wire logic                   exc_is_fault,
	input wire logic                   exc_is_trap,
	input wire logic                   hold_instruction,
	input wire logic                   ext_int_grant,
	input wire logic                   resume_flag,
	input wire logic                   trap_flag,
	input wire dbgx_pkg::dbgx_status_t debug_status_register
);
	import dbgx_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire dbgx_ctrl_t c      = debug_control_register;
	wire logic       gd_hit = clk_en && debug_reg_move && c.register_access_guard;
	logic [3:0]      ex_en;
	// A slot counts for fetches only when enabled and typed for execution.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			ex_en[i] = (c.global_slot_enable[i] | c.local_slot_enable[i])
				&& c.breakpoint_access_type_field[2*i +: 2] == DBGX_AT_EXEC;
	end
	wire logic ibp = clk_en && fetch_valid && |(fetch_slot_match & ex_en);
	property p_ibp;
		ibp && !resume_flag |=> hold_instruction && exc_is_fault;
	endproperty
	a_ibp: assert property (p_ibp) else $error("ibp fault");
	property p_gd;
		gd_hit |=> exc_is_fault && debug_status_register.access_detect_flag
			&& (resume_flag || $past(ibp && !resume_flag));
	endproperty
	a_gd: assert property (p_gd) else $error("guard fault");
	property p_data;
		clk_en && data_valid && !retire.valid && !rep_iter_done && !task_switch.valid
			|=> !exc_is_trap;
	endproperty
	a_data: assert property (p_data) else $error("early data trap");
	property p_step;
		clk_en && retire.valid && trap_flag |=> exc_is_trap && !trap_flag;
	endproperty
	a_step: assert property (p_step) else $error("step trap");
	property p_ts;
		clk_en && task_switch.valid && task_switch.debug_trap_bit
			|=> exc_is_trap && debug_status_register.task_switch_status_flag;
	endproperty
	a_ts: assert property (p_ts) else $error("task trap");
	property p_keep;
		!status_clear |=> (debug_status_register & $past(debug_status_register))
			== $past(debug_status_register);
	endproperty
	a_keep: assert property (p_keep) else $error("status lost");
	property p_rfc;
		clk_en && retire.valid && !(retire.kind inside {DBGX_RK_DW_PLAIN_INTERRUPT_RETURN, DBGX_RK_TS_BRANCH})
			&& !other_fault && !task_switch.valid && !gd_hit |=> !resume_flag;
	endproperty
	a_rfc: assert property (p_rfc) else $error("resume kept");
	property p_int;
		(clk_en && retire.valid && trap_flag && ext_int_pending) ##1 (clk_en && ext_int_pending)
			|-> ##1 ext_int_grant;
	endproperty
	a_int: assert property (p_int) else $error("no grant");
endmodule : dbgx_debug_exception_logic_checker
bind dbgx_debug_exception_logic dbgx_debug_exception_logic_checker u_chk
(
	.ref_clk, .reset, .clk_en, .debug_control_register, .fetch_valid, .fetch_slot_match,
	.debug_reg_move, .data_valid, .rep_iter_done, .retire, .task_switch, .other_fault,
	.ext_int_pending, .status_clear, .exc_is_fault, .exc_is_trap, .hold_instruction,
	.ext_int_grant, .resume_flag, .trap_flag, .debug_status_register
);
`default_nettype wire

// ==== dbgx_pipe_model.sv ====
// Purpose: Pipeline-side partner issuing fetches, accesses and retirements.
// Assumes: Each request is raised at a falling edge and stands until the next
//          call or an idle cycle replaces it.
// Notes:   Match bits flip while idle, so stale qualifiers are never trusted.
`timescale 1ns/1ns
`default_nettype none
module dbgx_pipe_model
(
	input  wire logic                  ref_clk,
	output var logic                   fetch_valid,
	output var logic [3:0]             fetch_slot_match,
	output var logic                   debug_reg_move,
	output var logic                   data_valid,
	output var logic                   data_write,
	output var logic                   data_is_io,
	output var logic [3:0]             data_slot_match,
	output var logic                   rep_iter_done,
	output var dbgx_pkg::dbgx_retire_t retire,
	output var dbgx_pkg::dbgx_task_t   task_switch,
	output var logic                   other_fault
);
	import dbgx_pkg::*;
	// Every strobe is written once per falling edge, so back-to-back requests
	// never show a zero-width low between them.
	task automatic put(input logic [6:0] v);
		{fetch_valid, debug_reg_move, data_valid, rep_iter_done, other_fault,
			retire.valid, task_switch.valid} = v;
	endtask : put
	// One quiet cycle; the match bits show their inverse so that a stale
	// qualifier is never mistaken for a request.
	task automatic idle();
		put(7'h00);
		fetch_slot_match = ~fetch_slot_match;
		data_slot_match = ~data_slot_match;
		@(negedge ref_clk);
	endtask : idle
	initial
	begin
		{fetch_valid, fetch_slot_match, debug_reg_move, data_valid, data_write, data_is_io,
			data_slot_match, rep_iter_done, retire, task_switch, other_fault} = '0;
	end
	task automatic fetch(input logic [3:0] m);
		put(7'h40);
		fetch_slot_match = m;
		@(negedge ref_clk);
	endtask : fetch
	task automatic data(input logic w, input logic io, input logic [3:0] m);
		put(7'h10);
		{data_write, data_is_io, data_slot_match} = {w, io, m};
		@(negedge ref_clk);
	endtask : data
	// Bits are other_fault, rep_iter_done and debug_reg_move, high to low.
	task automatic pulse(input logic [2:0] w);
		put({1'b0, w[0], 1'b0, w[1], w[2], 2'b00});
		@(negedge ref_clk);
	endtask : pulse
	task automatic ret(input dbgx_retire_kind_t k, input logic w, input logic v, input logic r);
		put(7'h02);
		retire.kind = k;
		{retire.tf_write, retire.tf_value, retire.rf_image} = {w, v, r};
		@(negedge ref_clk);
	endtask : ret
	// Switches into a handler task never set the debug-trap bit, or it would loop.
	task automatic tsw(input logic rt, input logic tf, input logic rf, input logic t);
		put(7'h01);
		{task_switch.is_return, task_switch.tf_image, task_switch.rf_image,
			task_switch.debug_trap_bit} = {rt, tf, rf, t};
		@(negedge ref_clk);
	endtask : tsw
endmodule : dbgx_pipe_model
`default_nettype wire

// ==== dbgx_debug_exception_logic_bench.sv ====
// Purpose: Self-checking bench for the debug exception logic.
// Assumes: Inputs change at the falling edge; outputs are read there too.
// Notes:   Every request lands one edge later, so checks follow each tick.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module dbgx_debug_exception_logic_bench;
	import dbgx_pkg::*;
	logic          ref_clk, reset, clk_en, status_clear, ext_int_pending;
	dbgx_ctrl_t    ctrl;
	dbgx_status_t  clr_mask;
	wire logic     fetch_valid, debug_reg_move, data_valid, data_write, data_is_io;
	wire logic     rep_iter_done, other_fault;
	wire logic     [3:0] fetch_slot_match, data_slot_match;
	wire dbgx_retire_t retire;
	wire dbgx_task_t   task_switch;
	wire logic     debug_exception, exc_is_fault, exc_is_trap, hold_instruction;
	wire logic     block_other_exc, ext_int_grant, resume_flag, trap_flag;
	wire logic     [7:0] exc_vector;
	wire dbgx_status_t debug_status_register;
	int            n_mismatch, comparisons, cyc;
	dbgx_pipe_model pipe
	(
		.ref_clk, .fetch_valid, .fetch_slot_match, .debug_reg_move, .data_valid,
		.data_write, .data_is_io, .data_slot_match, .rep_iter_done, .retire,
		.task_switch, .other_fault
	);
	dbgx_debug_exception_logic dut
	(
		.ref_clk, .reset, .clk_en, .debug_control_register(ctrl),
		.fetch_valid, .fetch_slot_match, .debug_reg_move, .data_valid, .data_write,
		.data_is_io, .data_slot_match, .rep_iter_done, .retire, .task_switch, .other_fault,
		.ext_int_pending, .status_clear, .status_clear_mask(clr_mask), .debug_exception,
		.exc_is_fault, .exc_is_trap, .exc_vector, .hold_instruction, .block_other_exc,
		.ext_int_grant, .resume_flag, .trap_flag, .debug_status_register
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_mismatch++;
			results();
		end
	end
	task automatic results();
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic expx(input logic f, input logic t);
		`CHK(debug_exception, f | t)
		`CHK(exc_is_fault, f)
		`CHK(exc_is_trap, t)
	endtask : expx
	initial
	begin
		{reset, clk_en, status_clear, ext_int_pending} = 4'hc;
		clr_mask = '1;
		ctrl = '0;
		ctrl.global_slot_enable = 4'h5;
		ctrl.local_slot_enable = 4'ha;
		// Slot 0 exec, 1 write, 2 i/o, 3 data read or write.
		ctrl.breakpoint_access_type_field = 8'he4;
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		`CHK(exc_vector, DBGX_VEC_DEBUG)
		pipe.fetch(4'h2);
		expx(1'b0, 1'b0);
		pipe.fetch(4'h1);
		expx(1'b1, 1'b0);
		`CHK({hold_instruction, block_other_exc, resume_flag}, 3'h6)
		`CHK(debug_status_register.slot_hit_flag, 4'h1)
		ctrl.register_access_guard = 1'b1;
		pipe.pulse(3'h1);
		expx(1'b1, 1'b0);
		`CHK({debug_status_register.access_detect_flag, resume_flag}, 2'h3)
		ctrl.register_access_guard = 1'b0;
		pipe.fetch(4'h1);
		expx(1'b0, 1'b0);
		// Exact-match bits are swept so any dependence on them shows up.
		for (int e = 0; e < 2; e++)
		begin
			ctrl.global_exact_match = e[0];
			ctrl.local_exact_match = e[0];
			for (int i = 1; i < 4; i++)
			begin
				pipe.data(i != 3, i == 2, 4'h1 << i);
				expx(1'b0, 1'b0);
				pipe.ret(DBGX_RK_NORMAL, 1'b0, 1'b0, 1'b0);
				expx(1'b0, 1'b1);
				`CHK(resume_flag, 1'b0)
			end
		end
		`CHK(debug_status_register.slot_hit_flag, 4'hf)
		pipe.data(1'b1, 1'b1, 4'h4);
		pipe.pulse(3'h2);
		expx(1'b0, 1'b1);
		status_clear = 1'b1;
		clr_mask = 7'h0f;
		pipe.idle();
		`CHK(debug_status_register, 7'h20)
		clr_mask = '1;
		pipe.idle();
		status_clear = 1'b0;
		`CHK(debug_status_register, DBGX_STATUS_RESET)
		// A frozen clock enable must let a live breakpoint fetch pass unseen.
		clk_en = 1'b0;
		pipe.fetch(4'h1);
		expx(1'b0, 1'b0);
		`CHK(debug_status_register, DBGX_STATUS_RESET)
		clk_en = 1'b1;
		pipe.ret(DBGX_RK_NORMAL, 1'b1, 1'b1, 1'b0);
		expx(1'b0, 1'b0);
		ext_int_pending = 1'b1;
		pipe.ret(DBGX_RK_NORMAL, 1'b0, 1'b0, 1'b0);
		expx(1'b0, 1'b1);
		`CHK({debug_status_register.step_status_flag, trap_flag}, 2'h2)
		pipe.idle();
		`CHK(ext_int_grant, 1'b1)
		ext_int_pending = 1'b0;
		pipe.tsw(1'b0, 1'b1, 1'b0, 1'b1);
		expx(1'b0, 1'b1);
		`CHK({debug_status_register.task_switch_status_flag, trap_flag}, 2'h3)
		pipe.ret(DBGX_RK_NORMAL, 1'b0, 1'b0, 1'b0);
		expx(1'b0, 1'b1);
		pipe.ret(DBGX_RK_SOFT_INT, 1'b1, 1'b1, 1'b0);
		`CHK(trap_flag, 1'b0)
		pipe.ret(DBGX_RK_OVF_INT, 1'b1, 1'b1, 1'b0);
		`CHK(trap_flag, 1'b0)
		pipe.ret(DBGX_RK_DW_PLAIN_INTERRUPT_RETURN, 1'b0, 1'b0, 1'b1);
		`CHK(resume_flag, 1'b1)
		pipe.ret(DBGX_RK_TS_BRANCH, 1'b0, 1'b0, 1'b0);
		`CHK(resume_flag, 1'b1)
		pipe.ret(DBGX_RK_PLAIN_PLAIN_INTERRUPT_RETURN, 1'b0, 1'b0, 1'b1);
		`CHK(resume_flag, 1'b0)
		pipe.ret(DBGX_RK_FLAG_POP, 1'b0, 1'b0, 1'b1);
		`CHK(resume_flag, 1'b0)
		pipe.tsw(1'b1, 1'b0, 1'b1, 1'b0);
		`CHK(resume_flag, 1'b1)
		pipe.ret(DBGX_RK_NORMAL, 1'b0, 1'b0, 1'b0);
		`CHK(resume_flag, 1'b0)
		pipe.pulse(3'h4);
		`CHK(resume_flag, 1'b1)
		results();
	end
endmodule : dbgx_debug_exception_logic_bench
`default_nettype wire
